/* wei_regs.vh */
// Register offsets, field positions, reserved-bit masks and reset values of the wake/enable block
`ifndef WEI_REGS_VH
`define WEI_REGS_VH

// ****************************************************************
// Byte offsets on the register bus, one aligned word each
// ****************************************************************
`define WEI_OFS_EDGE_SEL   5'h00
`define WEI_OFS_ENABLE_ONE 5'h04
`define WEI_OFS_ENABLE_TWO 5'h08
`define WEI_OFS_FLAGS_ONE  5'h0C
`define WEI_OFS_FLAGS_TWO  5'h10
`define WEI_OFS_WAKE_FLAGS 5'h14
`define WEI_OFS_EVT_STATUS 5'h18
`define WEI_OFS_EVT_MASK   5'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define WEI_BIT_DT         7
`define WEI_BIT_RTC        6
`define WEI_BIT_WAKE_EN    5
`define WEI_BIT_TMR2       5
`define WEI_EVT_DT         7
`define WEI_EVT_RTC        6
`define WEI_EVT_WAKE       5
`define WEI_EVT_TMR2       4

// ****************************************************************
// Writable masks and bits that always read as one
// ****************************************************************
`define WEI_ESEL_WMASK     8'h3F
`define WEI_ESEL_ONES      8'hC0
`define WEI_EN1_WMASK      8'hEF
`define WEI_EN1_ONES       8'h10
`define WEI_EN2_WMASK      8'h20
`define WEI_EN2_ONES       8'h1F
`define WEI_RF1_WMASK      8'hCF
`define WEI_RF1_ONES       8'h30
`define WEI_RF2_WMASK      8'h20
`define WEI_RF2_ONES       8'h1F
`define WEI_WF_WMASK       8'h3F
`define WEI_WF_ONES        8'hC0
`define WEI_EVT_WMASK      8'hFF

// ****************************************************************
// Reset value of every stored bit
// ****************************************************************
`define WEI_RST_VAL        8'h00

`endif

/* wei_edge_det.v */
// Pin synchroniser with per-pin rising or falling edge selection
`timescale 1ns/100ps
module wei_edge_det #(
    parameter W = 6
) (
    input  wire         clock,
    input  wire         arst_n,
    input  wire [W-1:0] pin,
    input  wire [W-1:0] rise_sel,
    output wire [W-1:0] edge_pulse
);
    reg  [W-1:0] sync1_r;
    reg  [W-1:0] sync2_r;
    reg  [W-1:0] prev_r;
    reg  [2:0]   arm_r;

    // Two-flop synchroniser, then one history stage; arm_r blocks a fake edge
    // until the history stage holds a real pin sample after reset
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_r <= {W{1'b0}};
            sync2_r <= {W{1'b0}};
            prev_r  <= {W{1'b0}};
            arm_r   <= 3'h0;
        end
        else
        begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            arm_r   <= {arm_r[1:0], 1'b1};
        end
    end

    // Select 1 takes a low-to-high change, select 0 a high-to-low change
    assign edge_pulse = {W{arm_r[2]}} &
                        ((rise_sel & sync2_r & ~prev_r) | (~rise_sel & ~sync2_r & prev_r));
endmodule // wei_edge_det

/* wei_sticky_flags.v */
// Bank of sticky flags where a hardware set always beats a clear
`timescale 1ns/100ps
module wei_sticky_flags #(
    parameter W = 8
) (
    input  wire         clock,
    input  wire         arst_n,
    input  wire [W-1:0] set,
    input  wire [W-1:0] clr,
    output wire [W-1:0] flags
);
    reg  [W-1:0] flags_r;
    wire [W-1:0] flags_nxt;

    // Clear first, then set, so an event that collides with a clear is kept
    assign flags_nxt = (flags_r & ~clr) | set;

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            flags_r <= {W{1'b0}};
        else
            flags_r <= flags_nxt;
    end

    assign flags = flags_r;
endmodule // wei_sticky_flags

/* wei_irq_ctrl.v */
// Wake edge select, interrupt enables, request flags and Avalon-MM register access
//
// Functional notes
// RULE1 - Edge select bits 7,6 always read one
// RULE2 - Edge bits 5..0: 0 falling, 1 rising
// RULE3 - Wake pin 5 edge also drives converter trigger
// RULE4 - Enable-one bit 7 enables direct transition
// RULE5 - Enable-one bit 6 enables real-time counter
// RULE6 - Enable-one bit 5 common to six wake pins
// RULE7 - Enable-one bit 4 always reads one
// RULE8 - Enable-one bits 3..0 enable external pins
// RULE9 - Enable-two bit 5 enables second timer overflow
// RULE10 - Enable-two bits 7,6 zero, 4..0 one
// RULE11 - Software clears only while CPU masked
// RULE12 - Request colliding with clear is still taken
// RULE13 - External pin flag set on edge, cleared by 0
// RULE14 - Six wake flags share common wake enable
// RULE15 - Counter overflow sets flag, write 0 clears
// RULE16 - Second timer overflow sets flag, 0 clears
// RULE17 - Request presented while flag and enable set
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "wei_regs.vh"
module wei_irq_ctrl (
    input  wire        clock,
    input  wire        arst_n,
    // Avalon-MM slave
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Pins and events
    input  wire [5:0]  wake_pins,
    input  wire [5:0]  wake_pin_irq_mode,
    input  wire [3:0]  ext_request_pins,
    input  wire [3:0]  ext_pin_irq_mode,
    input  wire [3:0]  ext_pin_rise_sel,
    input  wire        direct_transition_event,
    input  wire        rtc_overflow,
    input  wire        second_timer_overflow,
    // Requests towards the CPU and the converter trigger
    output wire        direct_transition_req,
    output wire        rtc_req,
    output wire        wake_req,
    output wire [3:0]  ext_pin_req,
    output wire        second_timer_req,
    output wire        converter_trigger_pulse,
    output wire        irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [7:0]  edge_sel_r;
    reg  [7:0]  enable_one_r;
    reg  [7:0]  enable_two_r;
    reg  [7:0]  evt_mask_r;
    reg  [31:0] readdata_r;
    reg  [7:0]  rd_nxt;
    reg         ack_r;
    reg         conv_trig_r;
    wire        req_any;
    wire        wr_go;
    wire        rd_go;
    wire        wr_lane0;
    wire [4:0]  word_ofs;
    wire [7:0]  wdata8;
    wire [5:0]  wake_edge;
    wire [3:0]  ext_edge;
    wire [7:0]  flags_one;
    wire [7:0]  flags_two;
    wire [7:0]  wake_flags;
    wire [7:0]  evt_status;
    wire [7:0]  flags_one_set;
    wire [7:0]  flags_two_set;
    wire [7:0]  wake_flags_set;
    wire [7:0]  evt_set;
    wire [7:0]  flags_one_clr;
    wire [7:0]  flags_two_clr;
    wire [7:0]  wake_flags_clr;
    wire [7:0]  evt_clr;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Read view: stored writable bits plus the bits that are fixed at one
    function [7:0] rd_view;
        input [7:0] val;
        input [7:0] wmask;
        input [7:0] ones;
        begin
            rd_view = (val & wmask) | ones;
        end
    endfunction

    // Write-zero-to-clear mask, limited to the flag bits of the register
    function [7:0] clr_mask;
        input       hit;
        input [7:0] wdata;
        input [7:0] wmask;
        begin
            clr_mask = hit ? (~wdata & wmask) : 8'h00;
        end
    endfunction

    // ****************************************************************
    // Avalon-MM handshake
    // ****************************************************************

    // Every access waits one cycle, then completes on the edge with waitrequest low
    assign req_any         = avs_read | avs_write;
    assign avs_waitrequest = req_any & ~ack_r;
    assign wr_go           = avs_write & ack_r;
    assign rd_go           = avs_read & ack_r;
    assign wr_lane0        = wr_go & avs_byteenable[0];
    assign word_ofs        = {avs_address[4:2], 2'b00};
    assign wdata8          = avs_writedata[7:0];

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ack_r <= 1'b0;
        else
            ack_r <= req_any & ~ack_r;
    end

    // Read mux; all eight word offsets are mapped and address bits 1:0 are ignored, so no offset reaches the zero default
    always @*
    begin
        rd_nxt = 8'h00;
        case (word_ofs)
            `WEI_OFS_EDGE_SEL:   rd_nxt = rd_view(edge_sel_r, `WEI_ESEL_WMASK,
                                                  `WEI_ESEL_ONES);            // [RULE1]
            `WEI_OFS_ENABLE_ONE: rd_nxt = rd_view(enable_one_r, `WEI_EN1_WMASK,
                                                  `WEI_EN1_ONES);             // [RULE7]
            `WEI_OFS_ENABLE_TWO: rd_nxt = rd_view(enable_two_r, `WEI_EN2_WMASK,
                                                  `WEI_EN2_ONES);             // [RULE10]
            `WEI_OFS_FLAGS_ONE:  rd_nxt = rd_view(flags_one, `WEI_RF1_WMASK, `WEI_RF1_ONES);
            `WEI_OFS_FLAGS_TWO:  rd_nxt = rd_view(flags_two, `WEI_RF2_WMASK, `WEI_RF2_ONES);
            `WEI_OFS_WAKE_FLAGS: rd_nxt = rd_view(wake_flags, `WEI_WF_WMASK, `WEI_WF_ONES);
            `WEI_OFS_EVT_STATUS: rd_nxt = evt_status;
            `WEI_OFS_EVT_MASK:   rd_nxt = evt_mask_r;
            default:             rd_nxt = 8'h00;
        endcase
    end

    // Read data is captured in the waiting cycle and held through the answer
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            readdata_r <= 32'h0000_0000;
        else if (avs_read & ~ack_r)
            readdata_r <= {24'h00_0000, rd_nxt};
    end

    assign avs_readdata = readdata_r;

    // ****************************************************************
    // Control registers
    // ****************************************************************

    // Only writable bits are stored; fixed bits come from the read view
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            edge_sel_r   <= `WEI_RST_VAL;                                    // [RULE2]
            enable_one_r <= `WEI_RST_VAL;
            enable_two_r <= `WEI_RST_VAL;
            evt_mask_r   <= `WEI_RST_VAL;
        end
        else if (wr_lane0)
        begin
            if (word_ofs == `WEI_OFS_EDGE_SEL)
                edge_sel_r <= wdata8 & `WEI_ESEL_WMASK;                      // [RULE1]
            if (word_ofs == `WEI_OFS_ENABLE_ONE)
                enable_one_r <= wdata8 & `WEI_EN1_WMASK;                     // [RULE7]
            if (word_ofs == `WEI_OFS_ENABLE_TWO)
                enable_two_r <= wdata8 & `WEI_EN2_WMASK;                     // [RULE10]
            if (word_ofs == `WEI_OFS_EVT_MASK)
                evt_mask_r <= wdata8 & `WEI_EVT_WMASK;
        end
    end

    // ****************************************************************
    // Edge detection
    // ****************************************************************

    // Wake pins use the stored edge selects
    wei_edge_det #(
        .W          (6)
    ) u_wake_edge (
        .clock      (clock),
        .arst_n     (arst_n),
        .pin        (wake_pins),
        .rise_sel   (edge_sel_r[5:0]),                                       // [RULE2]
        .edge_pulse (wake_edge)
    );

    // External pins take their edge selects from the neighbouring control block
    wei_edge_det #(
        .W          (4)
    ) u_ext_edge (
        .clock      (clock),
        .arst_n     (arst_n),
        .pin        (ext_request_pins),
        .rise_sel   (ext_pin_rise_sel),
        .edge_pulse (ext_edge)
    );

    // Pin 5 is shared; the trigger follows the same edge even when not in interrupt mode
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            conv_trig_r <= 1'b0;
        else
            conv_trig_r <= wake_edge[5];                                     // [RULE3]
    end

    assign converter_trigger_pulse = conv_trig_r;

    // ****************************************************************
    // Request flags
    // ****************************************************************

    // Flag sets; a pin flag needs the pin to be in interrupt mode
    assign flags_one_set  = {direct_transition_event,
                             rtc_overflow,                                   // [RULE15]
                             2'b00,
                             ext_edge & ext_pin_irq_mode};                   // [RULE13]
    assign flags_two_set  = {2'b00, second_timer_overflow, 5'b0_0000};       // [RULE16]
    assign wake_flags_set = {2'b00, wake_edge & wake_pin_irq_mode};          // [RULE14]

    // Writing zero clears a flag; writing one leaves it
    assign flags_one_clr  = clr_mask(wr_lane0 & (word_ofs == `WEI_OFS_FLAGS_ONE),
                                     wdata8, `WEI_RF1_WMASK);                // [RULE13]
    assign flags_two_clr  = clr_mask(wr_lane0 & (word_ofs == `WEI_OFS_FLAGS_TWO),
                                     wdata8, `WEI_RF2_WMASK);                // [RULE16]
    assign wake_flags_clr = clr_mask(wr_lane0 & (word_ofs == `WEI_OFS_WAKE_FLAGS),
                                     wdata8, `WEI_WF_WMASK);

    // Set beats clear, so an unmasked clear never loses a colliding request
    wei_sticky_flags #(
        .W     (8)
    ) u_flags_one (
        .clock (clock),
        .arst_n(arst_n),
        .set   (flags_one_set),                                              // [RULE12]
        .clr   (flags_one_clr),
        .flags (flags_one)
    );

    wei_sticky_flags #(
        .W     (8)
    ) u_flags_two (
        .clock (clock),
        .arst_n(arst_n),
        .set   (flags_two_set),                                              // [RULE12]
        .clr   (flags_two_clr),
        .flags (flags_two)
    );

    wei_sticky_flags #(
        .W     (8)
    ) u_wake_flags (
        .clock (clock),
        .arst_n(arst_n),
        .set   (wake_flags_set),                                             // [RULE12]
        .clr   (wake_flags_clr),
        .flags (wake_flags)
    );

    // ****************************************************************
    // Requests to the CPU
    // ****************************************************************

    // Straight AND of flag and enable flops, so a clear withdraws at the next edge
    assign direct_transition_req = flags_one[`WEI_BIT_DT] &
                                   enable_one_r[`WEI_BIT_DT];                // [RULE4] [RULE17]
    assign rtc_req               = flags_one[`WEI_BIT_RTC] &
                                   enable_one_r[`WEI_BIT_RTC];               // [RULE5] [RULE17]
    assign wake_req              = (|wake_flags[5:0]) &
                                   enable_one_r[`WEI_BIT_WAKE_EN];           // [RULE6] [RULE14]
    assign ext_pin_req           = flags_one[3:0] & enable_one_r[3:0];       // [RULE8] [RULE17]
    assign second_timer_req      = flags_two[`WEI_BIT_TMR2] &
                                   enable_two_r[`WEI_BIT_TMR2];              // [RULE9] [RULE17]

    // ****************************************************************
    // Event status, mask and interrupt line
    // ****************************************************************

    // Any flag set also lands in the event status
    assign evt_set = {flags_one_set[`WEI_BIT_DT],
                      flags_one_set[`WEI_BIT_RTC],
                      |wake_flags_set,
                      second_timer_overflow,
                      flags_one_set[3:0]};

    // Clearing only the bits captured by this read keeps later events
    assign evt_clr = (rd_go & (word_ofs == `WEI_OFS_EVT_STATUS)) ? readdata_r[7:0] : 8'h00;

    wei_sticky_flags #(
        .W     (8)
    ) u_evt_status (
        .clock (clock),
        .arst_n(arst_n),
        .set   (evt_set),
        .clr   (evt_clr),
        .flags (evt_status)
    );

    assign irq = |(evt_status & evt_mask_r);

endmodule // wei_irq_ctrl

/* wei_irq_ctrl_asserts.sv */
// Checker of the wake/enable interrupt block, watching its ports only
`timescale 1ns/100ps
`include "wei_regs.vh"
module wei_irq_ctrl_asserts (
    input wire        clock,
    input wire        arst_n,
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [5:0]  wake_pins,
    input wire [5:0]  wake_pin_irq_mode,
    input wire [3:0]  ext_request_pins,
    input wire [3:0]  ext_pin_irq_mode,
    input wire [3:0]  ext_pin_rise_sel,
    input wire        direct_transition_event,
    input wire        rtc_overflow,
    input wire        second_timer_overflow,
    input wire        direct_transition_req,
    input wire        rtc_req,
    input wire        wake_req,
    input wire [3:0]  ext_pin_req,
    input wire        second_timer_req,
    input wire        converter_trigger_pulse,
    input wire        irq
);
    // ****************************************************************
    // One clock domain, so clock and reset are given once
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Every access waits exactly one cycle, no more
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access waited more than one cycle");
    AST_ESEL_ONES: assert property (
        avs_read && !avs_waitrequest && avs_address[4:2] == 3'd0 |-> avs_readdata[7:6] == 2'b11)
        else $error("edge select top bits not one");
    AST_EN1_ONE: assert property (
        avs_read && !avs_waitrequest && avs_address[4:2] == 3'd1 |-> avs_readdata[4])
        else $error("enable one bit 4 not one");
    AST_EN2_FIX: assert property (
        avs_read && !avs_waitrequest && avs_address[4:2] == 3'd2
        |-> (avs_readdata[7:0] & 8'hDF) == 8'h1F) else $error("enable two fixed bits");
    // A request only rises after its event or a register write
    AST_DT_CAUSE: assert property (
        $rose(direct_transition_req) |-> $past(direct_transition_event) || $past(avs_write))
        else $error("dt request");
    AST_RTC_CAUSE: assert property (
        $rose(rtc_req) |-> $past(rtc_overflow) || $past(avs_write))
        else $error("rtc request without cause");
    AST_TMR_CAUSE: assert property (
        $rose(second_timer_req) |-> $past(second_timer_overflow) || $past(avs_write))
        else $error("timer req");
    // Without a write nothing withdraws a pending request
    AST_RTC_HOLD: assert property (rtc_req && !avs_write |=> rtc_req)
        else $error("rtc request dropped");
    AST_WAKE_HOLD: assert property (wake_req && !avs_write |=> wake_req)
        else $error("wake request dropped");
    AST_EXT_HOLD: assert property (
        !avs_write |=> (ext_pin_req & $past(ext_pin_req)) == $past(ext_pin_req))
        else $error("ext request dropped");
    AST_CONV_PULSE: assert property (
        converter_trigger_pulse |=> !converter_trigger_pulse)
        else $error("trigger pulse too long");
endmodule // wei_irq_ctrl_asserts

/* wei_cpu_side.sv */
// Far-side model: CPU event sources, external pins and the CPU interrupt mask
`timescale 1ns/100ps
module wei_cpu_side (
    input  wire       clock,
    output reg  [5:0] wake_pins,
    output reg  [3:0] ext_request_pins,
    output reg        direct_transition_event,
    output reg        rtc_overflow,
    output reg        second_timer_overflow
);
    // Software clears enables and flags only while this mask is set
    reg cpu_masked_r;

    // Pin levels chosen so one toggle makes every selected edge
    initial
    begin
        cpu_masked_r = 1'b1;
        wake_pins = 6'h15;
        ext_request_pins = 4'hA;
        {direct_transition_event, rtc_overflow, second_timer_overflow} = 3'b000;
    end

    // One-cycle event pulses, launched right after a rising edge
    task pulse(input [2:0] which);
    begin
        @(posedge clock);
        {direct_transition_event, rtc_overflow, second_timer_overflow} <= which;
        @(posedge clock);
        {direct_transition_event, rtc_overflow, second_timer_overflow} <= 3'b000;
    end
    endtask

    // Toggle the chosen pins at once
    task flip(input [5:0] w, input [3:0] e);
    begin
        @(posedge clock);
        wake_pins <= wake_pins ^ w;
        ext_request_pins <= ext_request_pins ^ e;
    end
    endtask
endmodule // wei_cpu_side

/* tb_wei_irq_ctrl.sv */
// Self-checking bench of the wake/enable interrupt block
`timescale 1ns/100ps
`include "wei_regs.vh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %0t got %h expected %h", $time, got, exp); end end
module tb_wei_irq_ctrl;
    reg         clock, arst_n, avs_read, avs_write;
    reg  [4:0]  avs_address;
    reg  [31:0] avs_writedata;
    reg  [3:0]  avs_byteenable, ext_pin_irq_mode, ext_pin_rise_sel;
    reg  [5:0]  wake_pin_irq_mode;
    wire [31:0] avs_readdata;
    wire [5:0]  wake_pins;
    wire [3:0]  ext_request_pins, ext_pin_req;
    wire        avs_waitrequest, direct_transition_event, rtc_overflow, second_timer_overflow;
    wire        direct_transition_req, rtc_req, wake_req, second_timer_req;
    wire        converter_trigger_pulse, irq;
    integer     mismatches, tests_run, cycles, conv_cnt, i, seed, rnd;
    reg  [7:0]  exp_q[$];
    reg  [7:0]  e, r;
    localparam [63:0] RST_TAB = 64'h0000_C01F_301F_10C0;

    wei_irq_ctrl u_wei_irq_ctrl (.clock, .arst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .wake_pins,
        .wake_pin_irq_mode, .ext_request_pins, .ext_pin_irq_mode, .ext_pin_rise_sel,
        .direct_transition_event, .rtc_overflow, .second_timer_overflow, .direct_transition_req,
        .rtc_req, .wake_req, .ext_pin_req, .second_timer_req, .converter_trigger_pulse, .irq);
    wei_cpu_side u_wei_cpu_side (.clock, .wake_pins, .ext_request_pins, .direct_transition_event,
        .rtc_overflow, .second_timer_overflow);

    always #2.5 clock = ~clock;

    // Read data is taken at the very edge that completes the read, as the master would
    always @(posedge clock)
    begin
        if (avs_read && !avs_waitrequest)
        begin
            e = exp_q.pop_front();
            `CHK(avs_readdata, {24'h00_0000, e})
        end
        if (converter_trigger_pulse)
            conv_cnt = conv_cnt + 1;
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            final_report;
        end
    end

    // Hold the request until waitrequest is sampled low at a rising edge, release at that edge
    task xfer;
    begin
        @(posedge clock);
        while (avs_waitrequest)
            @(posedge clock);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    end
    endtask

    task bus_wr(input [4:0] a, input [7:0] d, input [3:0] be);
    begin
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        xfer;
    end
    endtask

    task bus_rd(input [4:0] a, input [7:0] x);
    begin
        exp_q.push_back(x);
        @(posedge clock);
        avs_address <= a;
        avs_read <= 1'b1;
        xfer;
    end
    endtask

    task final_report;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {clock, arst_n, avs_read, avs_write, avs_address, avs_writedata} = 0;
        {mismatches, tests_run, cycles, conv_cnt} = 0;
        avs_byteenable = 4'hF;
        wake_pin_irq_mode = 6'h3F;
        ext_pin_irq_mode = 4'hF;
        ext_pin_rise_sel = 4'h5;
        seed = 32'h307f_b0e0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        for (i = 0; i < 8; i++)
            bus_rd({i[2:0], 2'b00}, RST_TAB[i*8 +: 8]);
        $display("reset values done");
        // Stored bits follow random writes, fixed bits never move
        repeat (4)
        begin
            rnd = $random(seed);
            r = rnd[7:0];
            bus_wr(`WEI_OFS_EDGE_SEL, r, 4'hF);
            bus_wr(`WEI_OFS_ENABLE_ONE, r, 4'h1);
            bus_wr(`WEI_OFS_ENABLE_TWO, r, 4'h1);
            bus_rd(`WEI_OFS_EDGE_SEL, r | 8'hC0);
            bus_rd(`WEI_OFS_ENABLE_ONE, r | 8'h10);
            bus_rd(`WEI_OFS_ENABLE_TWO, (r & 8'h20) | 8'h1F);
        end
        bus_wr(`WEI_OFS_ENABLE_ONE, 8'h00, 4'hE);
        bus_rd(`WEI_OFS_ENABLE_ONE, r | 8'h10);
        $display("register access done");
        // Events raise requests; clearing a flag or enable withdraws them
        bus_wr(`WEI_OFS_ENABLE_ONE, 8'hE3, 4'h1);
        bus_wr(`WEI_OFS_ENABLE_TWO, 8'h20, 4'h1);
        u_wei_cpu_side.pulse(3'b111);
        @(negedge clock);
        `CHK({direct_transition_req, rtc_req, second_timer_req}, 3'b111)
        bus_wr(`WEI_OFS_FLAGS_ONE, 8'hBF, 4'h1);
        @(negedge clock);
        `CHK({direct_transition_req, rtc_req}, 2'b10)
        bus_wr(`WEI_OFS_ENABLE_ONE, 8'h63, 4'h1);
        @(negedge clock);
        `CHK(direct_transition_req, 1'b0)
        bus_rd(`WEI_OFS_FLAGS_ONE, 8'hB0);
        // Overflow arriving at the very edge of a clearing write still wins
        fork
            bus_wr(`WEI_OFS_FLAGS_TWO, 8'h00, 4'h1);
            begin
                @(posedge clock);
                u_wei_cpu_side.pulse(3'b001);
            end
        join
        @(negedge clock);
        `CHK(second_timer_req, 1'b1)
        bus_wr(`WEI_OFS_FLAGS_TWO, 8'h00, 4'h1);
        @(negedge clock);
        `CHK(second_timer_req, 1'b0)
        bus_rd(`WEI_OFS_FLAGS_TWO, 8'h1F);
        $display("event requests done");
        // Selected edges flag all pins; opposite edges flag no wake pin
        bus_wr(`WEI_OFS_EDGE_SEL, 8'h2A, 4'h1);
        bus_wr(`WEI_OFS_ENABLE_ONE, 8'h23, 4'h1);
        u_wei_cpu_side.flip(6'h3F, 4'hF);
        repeat (8) @(negedge clock);
        `CHK({wake_req, ext_pin_req}, 5'b1_0011)
        `CHK(conv_cnt, 1)
        bus_rd(`WEI_OFS_WAKE_FLAGS, 8'hFF);
        bus_rd(`WEI_OFS_FLAGS_ONE, 8'hBF);
        bus_wr(`WEI_OFS_WAKE_FLAGS, 8'hC0, 4'h1);
        u_wei_cpu_side.flip(6'h3F, 4'hF);
        repeat (8) @(negedge clock);
        `CHK({wake_req, conv_cnt}, {1'b0, 32'd1})
        bus_rd(`WEI_OFS_WAKE_FLAGS, 8'hC0);
        $display("pin edges done");
        // Interrupt line: masked, unmasked, then cleared by a status read
        bus_wr(`WEI_OFS_EVT_MASK, 8'h00, 4'h1);
        @(negedge clock);
        `CHK(irq, 1'b0)
        bus_wr(`WEI_OFS_EVT_MASK, 8'hFF, 4'h1);
        @(negedge clock);
        `CHK(irq, 1'b1)
        bus_wr(`WEI_OFS_FLAGS_ONE, 8'h30, 4'h1);
        bus_rd(`WEI_OFS_EVT_STATUS, 8'hFF);
        bus_rd(`WEI_OFS_EVT_STATUS, 8'h00);
        @(negedge clock);
        `CHK({irq, exp_q.size()}, {1'b0, 32'd0})
        $display("interrupt line done");
        // Pins out of interrupt mode flag nothing; the trigger still follows pin 5
        @(posedge clock);
        wake_pin_irq_mode <= 6'h00;
        ext_pin_irq_mode <= 4'h0;
        u_wei_cpu_side.flip(6'h3F, 4'hF);
        repeat (8) @(negedge clock);
        bus_rd(`WEI_OFS_WAKE_FLAGS, 8'hC0);
        @(negedge clock);
        `CHK({irq, wake_req, ext_pin_req, conv_cnt}, {6'h00, 32'd2})
        $display("irq mode gating done");
        final_report;
    end
endmodule // tb_wei_irq_ctrl

bind wei_irq_ctrl wei_irq_ctrl_asserts u_wei_irq_ctrl_asserts (.clock, .arst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .wake_pins, .wake_pin_irq_mode, .ext_request_pins, .ext_pin_irq_mode, .ext_pin_rise_sel,
    .direct_transition_event, .rtc_overflow, .second_timer_overflow, .direct_transition_req,
    .rtc_req, .wake_req, .ext_pin_req, .second_timer_req, .converter_trigger_pulse, .irq);
